// file: src/alarm_value_pkg.sv
// package: register map, field layout and types of the alarm value register set
package alarm_value_pkg;
    localparam int ADDR_WIDTH = 4;
    localparam int DATA_WIDTH = 16;
    localparam logic [3:0] OFFSET_MONTH_DAY = 4'h0;
    localparam logic [3:0] OFFSET_WEEKDAY_HOURS = 4'h1;
    localparam logic [3:0] OFFSET_MINUTES_SECONDS = 4'h2;
    localparam logic [3:0] OFFSET_CONTROL = 4'h3;
    // month/day layout
    localparam int MONTH_TENS_POS = 12;
    localparam int MONTH_ONES_LSB = 8;
    localparam int DAY_TENS_LSB = 4;
    localparam int DAY_ONES_LSB = 0;
    // weekday/hours layout
    localparam int WEEKDAY_LSB = 8;
    localparam int HOUR_TENS_LSB = 4;
    localparam int HOUR_ONES_LSB = 0;
    // minutes/seconds layout
    localparam int MINUTE_TENS_LSB = 12;
    localparam int MINUTE_ONES_LSB = 8;
    localparam int SECOND_TENS_LSB = 4;
    localparam int SECOND_ONES_LSB = 0;
    // control register layout
    localparam int UNLOCK_POS = 0;
    localparam int ENABLE_POS = 1;
    localparam int MASK_LSB = 4;
    // reset values
    localparam logic [15:0] FIELD_RESET = 16'h0000;
    localparam logic [3:0] MASK_RESET = 4'h0;
    // writable bits of each value register
    localparam logic [15:0] MONTH_DAY_USED = 16'h1f3f;
    localparam logic [15:0] WEEKDAY_HOURS_USED = 16'h073f;
    localparam logic [15:0] MINUTES_SECONDS_USED = 16'h7f7f;

    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } bus_request_type;

    typedef struct packed {
        logic [15:0] month_day;
        logic [15:0] weekday_hours;
        logic [15:0] minutes_seconds;
    } clock_value_type;
endpackage

// file: src/alarm_value_regs.sv
// alarm value register set with write unlock on month/day and weekday/hours and masked time comparison
`timescale 1ns/1ps
module alarm_value_regs
    import alarm_value_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire bus_request_type bus_req,
    output logic [15:0] read_data,
    input wire clock_value_type clock_now,
    input wire logic clock_tick,
    output logic alarm_pulse,
    output logic clock_write_unlock,
    output logic alarm_enable_bit
);
    logic [15:0] alarm_month_day;
    logic [15:0] alarm_weekday_hours;
    logic [15:0] alarm_minutes_seconds;
    logic [3:0] alarm_interval_mask;

    function automatic logic hit(input logic [3:0] a, input logic [3:0] o);
        hit = bus_req.write && (a == o);
    endfunction

    wire write_month_day = hit(bus_req.addr, OFFSET_MONTH_DAY) && clock_write_unlock;
    wire write_weekday_hours = hit(bus_req.addr, OFFSET_WEEKDAY_HOURS)
        && clock_write_unlock;
    wire write_minutes_seconds = hit(bus_req.addr, OFFSET_MINUTES_SECONDS);
    wire write_control = hit(bus_req.addr, OFFSET_CONTROL);

    // field views
    wire logic alarm_month_tens_digit = alarm_month_day[MONTH_TENS_POS];
    wire logic [3:0] alarm_month_ones_digit = alarm_month_day[MONTH_ONES_LSB +: 4];
    wire logic [1:0] alarm_day_tens_digit = alarm_month_day[DAY_TENS_LSB +: 2];
    wire logic [3:0] alarm_day_ones_digit = alarm_month_day[DAY_ONES_LSB +: 4];
    wire logic [2:0] alarm_weekday_digit = alarm_weekday_hours[WEEKDAY_LSB +: 3];
    wire logic [1:0] alarm_hour_tens_digit = alarm_weekday_hours[HOUR_TENS_LSB +: 2];
    wire logic [3:0] alarm_hour_ones_digit = alarm_weekday_hours[HOUR_ONES_LSB +: 4];
    wire logic [2:0] alarm_minute_tens_digit = alarm_minutes_seconds[MINUTE_TENS_LSB +: 3];
    wire logic [3:0] alarm_minute_ones_digit = alarm_minutes_seconds[MINUTE_ONES_LSB +: 4];
    wire logic [2:0] alarm_second_tens_digit = alarm_minutes_seconds[SECOND_TENS_LSB +: 3];
    wire logic [3:0] alarm_second_ones_digit = alarm_minutes_seconds[SECOND_ONES_LSB +: 4];

    // digit equality against running clock
    wire logic [15:0] md_eq = ~(alarm_month_day ^ clock_now.month_day) | ~MONTH_DAY_USED;
    wire logic [15:0] wh_eq = ~(alarm_weekday_hours ^ clock_now.weekday_hours)
        | ~WEEKDAY_HOURS_USED;
    wire logic [15:0] ms_eq = ~(alarm_minutes_seconds ^ clock_now.minutes_seconds)
        | ~MINUTES_SECONDS_USED;
    wire logic sec_ones_eq = &ms_eq[3:0];
    wire logic sec_eq = &ms_eq[7:0];
    wire logic min_ones_eq = sec_eq && (&ms_eq[11:8]);
    wire logic min_eq = &ms_eq;
    wire logic hour_eq = min_eq && (&wh_eq[7:0]);
    wire logic weekday_eq = hour_eq && (&wh_eq[10:8]);
    wire logic day_eq = hour_eq && (&md_eq[7:0]);
    wire logic month_eq = day_eq && (&md_eq);

    // interval mask: 0 and 1 every tick, rising mask up to 9 widens the compared digits except at 8, which compares weekday in place of day; 10-15 as 9
    logic mask_match;
    always_comb begin
        case (alarm_interval_mask)
            4'h0: mask_match = 1'b1;
            4'h1: mask_match = 1'b1;
            4'h2: mask_match = sec_ones_eq;
            4'h3: mask_match = sec_eq;
            4'h4: mask_match = min_ones_eq;
            4'h5: mask_match = min_eq;
            4'h6: mask_match = hour_eq;
            4'h7: mask_match = day_eq;
            4'h8: mask_match = weekday_eq;
            4'h9: mask_match = month_eq;
            default: mask_match = month_eq;
        endcase
    end
    wire logic alarm_fire = alarm_enable_bit && clock_tick && mask_match;

    wire logic [15:0] control_view = {8'h00, alarm_interval_mask, 2'b00,
        alarm_enable_bit, clock_write_unlock};
    logic [15:0] next_read_data;
    always_comb begin
        case (bus_req.addr)
            OFFSET_MONTH_DAY: next_read_data = alarm_month_day & MONTH_DAY_USED;
            OFFSET_WEEKDAY_HOURS: next_read_data = alarm_weekday_hours
                & WEEKDAY_HOURS_USED;
            OFFSET_MINUTES_SECONDS: next_read_data = alarm_minutes_seconds
                & MINUTES_SECONDS_USED;
            OFFSET_CONTROL: next_read_data = control_view;
            default: next_read_data = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            alarm_month_day <= FIELD_RESET;
            alarm_weekday_hours <= FIELD_RESET;
            alarm_minutes_seconds <= FIELD_RESET;
        end else begin
            if (write_month_day) begin
                alarm_month_day <= bus_req.wdata & MONTH_DAY_USED;
            end
            if (write_weekday_hours) begin
                alarm_weekday_hours <= bus_req.wdata & WEEKDAY_HOURS_USED;
            end
            if (write_minutes_seconds) begin
                alarm_minutes_seconds <= bus_req.wdata & MINUTES_SECONDS_USED;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            clock_write_unlock <= 1'b0;
            alarm_interval_mask <= MASK_RESET;
            alarm_enable_bit <= 1'b0;
        end else begin
            if (write_control) begin
                clock_write_unlock <= bus_req.wdata[UNLOCK_POS];
                alarm_interval_mask <= bus_req.wdata[MASK_LSB +: 4];
            end
            // hardware clear on alarm wins over a software set
            if (alarm_fire) begin
                alarm_enable_bit <= 1'b0;
            end else if (write_control) begin
                alarm_enable_bit <= bus_req.wdata[ENABLE_POS];
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= 16'h0000;
            alarm_pulse <= 1'b0;
        end else begin
            read_data <= bus_req.read ? next_read_data : 16'h0000;
            alarm_pulse <= alarm_fire;
        end
    end
endmodule

// file: verification/alarm_value_regs_assertions.sv
// checker: bus answer, field masks, write lock and alarm timing
`timescale 1ns/1ps
module alarm_value_regs_assertions
    import alarm_value_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire bus_request_type bus_req,
    input wire logic [15:0] read_data,
    input wire clock_value_type clock_now,
    input wire logic clock_tick,
    input wire logic alarm_pulse,
    input wire logic clock_write_unlock,
    input wire logic alarm_enable_bit
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire rd0 = bus_req.read && bus_req.addr == OFFSET_MONTH_DAY;
    wire rd1 = bus_req.read && bus_req.addr == OFFSET_WEEKDAY_HOURS;
    wire rd2 = bus_req.read && bus_req.addr == OFFSET_MINUTES_SECONDS;
    wire wr0 = bus_req.write && bus_req.addr == OFFSET_MONTH_DAY;
    wire wr3 = bus_req.write && bus_req.addr == OFFSET_CONTROL;
    sequence s_lock;
        rd0 ##1 (wr0 && !clock_write_unlock) ##1 rd0;
    endsequence
    property p_idle_zero; !bus_req.read |=> read_data == 16'h0000; endproperty
    property p_md_mask; rd0 |=> (read_data & ~MONTH_DAY_USED) == 16'h0000; endproperty
    property p_wh_mask; rd1 |=> (read_data & ~WEEKDAY_HOURS_USED) == 16'h0000; endproperty
    property p_ms_mask; rd2 |=> (read_data & ~MINUTES_SECONDS_USED) == 16'h0000; endproperty
    property p_lock; s_lock |=> read_data == $past(read_data, 2); endproperty
    property p_unlock; wr3 |=> clock_write_unlock == $past(bus_req.wdata[0]); endproperty
    property p_cause; alarm_pulse |-> $past(clock_tick && alarm_enable_bit) && !alarm_enable_bit;
    endproperty
    property p_once; alarm_pulse |=> !alarm_pulse; endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("read data not zero");
    a_md_mask: assert property (p_md_mask) else $error("month day spare bits set");
    a_wh_mask: assert property (p_wh_mask) else $error("weekday hour spare bits set");
    a_ms_mask: assert property (p_ms_mask) else $error("minute second spare bits set");
    a_lock: assert property (p_lock) else $error("locked write changed value");
    a_unlock: assert property (p_unlock) else $error("unlock bit not written");
    a_cause: assert property (p_cause) else $error("alarm without enabled tick");
    a_once: assert property (p_once) else $error("alarm pulse too long");
    c_alarm: cover property (alarm_pulse);
    c_lock: cover property (s_lock);
    c_read: cover property (rd0 ##1 read_data != 16'h0000);
endmodule

bind alarm_value_regs alarm_value_regs_assertions alarm_value_regs_assertions_inst (.core_clk,
    .rst_n, .bus_req, .read_data, .clock_now, .clock_tick, .alarm_pulse, .clock_write_unlock,
    .alarm_enable_bit);

// file: verification/alarm_value_regs_tb.sv
// testbench: register access, write lock and alarm match
`timescale 1ns/1ps
module alarm_value_regs_tb;
    import alarm_value_pkg::*;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    bus_request_type bus_req = '0;
    clock_value_type clock_now = '0;
    logic clock_tick = 1'b0;
    logic [15:0] read_data;
    logic alarm_pulse, clock_write_unlock, alarm_enable_bit;
    int error_cnt = 0;
    int cmp_count = 0;
    logic [35:0] rows [8] = '{36'h3_0001_0001, 36'h0_ffff_1f3f, 36'h0_1239_1239, 36'h1_ffff_073f,
        36'h1_0623_0623, 36'h2_ffff_7f7f, 36'h2_0102_0102, 36'h4_ffff_0000};
    logic [35:0] ticks [6] = '{36'h0092_0304_1, 36'h0090_0304_0, 36'h0092_0305_0,
        36'h0032_0504_1, 36'h0022_0305_0, 36'h0012_5959_1};
    alarm_value_regs alarm_value_regs_inst (.core_clk, .rst_n, .bus_req, .read_data, .clock_now,
        .clock_tick, .alarm_pulse, .clock_write_unlock, .alarm_enable_bit);
    always #20 core_clk = ~core_clk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        bus_req <= {a, d, 2'b10};
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        bus_req <= {a, 16'h0000, 2'b01};
        @(posedge core_clk);
        fork
            #1 chk(read_data, e);
        join_none
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (1000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        #1 chk({14'h0, clock_write_unlock, alarm_enable_bit}, 16'h0000);
        rd(OFFSET_MONTH_DAY, FIELD_RESET);
        $display("reset test done");
        foreach (rows[i]) begin
            wr(rows[i][35:32], rows[i][31:16]);
            rd(rows[i][35:32], rows[i][15:0]);
        end
        $display("register table test done");
        wr(OFFSET_CONTROL, 16'h0000);
        rd(OFFSET_MONTH_DAY, 16'h1239);
        wr(OFFSET_MONTH_DAY, 16'h0101);
        rd(OFFSET_MONTH_DAY, 16'h1239);
        wr(OFFSET_WEEKDAY_HOURS, 16'h0101);
        rd(OFFSET_WEEKDAY_HOURS, 16'h0623);
        wr(OFFSET_MINUTES_SECONDS, 16'h0304);
        rd(OFFSET_MINUTES_SECONDS, 16'h0304);
        $display("write lock test done");
        clock_now <= {16'h1239, 16'h0623, 16'h0000};
        foreach (ticks[i]) begin
            wr(OFFSET_CONTROL, ticks[i][35:20]);
            bus_req <= '0;
            clock_now.minutes_seconds <= ticks[i][19:4];
            clock_tick <= 1'b1;
            @(posedge core_clk);
            clock_tick <= 1'b0;
            #1 chk({alarm_pulse, alarm_enable_bit}, {ticks[i][0], ticks[i][21] & ~ticks[i][0]});
            @(posedge core_clk);
        end
        $display("alarm match test done");
        rst_n <= 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        rd(OFFSET_MINUTES_SECONDS, FIELD_RESET);
        rd(OFFSET_CONTROL, 16'h0000);
        @(posedge core_clk);
        $display("mid-run reset test done");
        conclude();
    end
endmodule
